// file: hdl/shutter_trigger_config_decoder.sv
/*
 * Shutter trigger configuration decoder. Host command bytes arrive through
 * an AXI4-Lite command register; two-byte commands set the trigger and sync
 * modes, restore defaults or save the configuration. Each command is
 * answered with a completion byte read back from the status register.
 * Assumes trig_in is synchronous to aclk; persistent store is a register
 * that survives aresetn (powered-up value is the factory default).
 */
// Contract
// - A1: shutter open while trigger high, closed while low.
// - A2: shutter open while trigger low, closed while high.
// - A3: toggle shutter on each trigger rising edge.
// - A4: toggle shutter on each trigger falling edge.
// - B0: sync output never signals shutter open.
// - B2: sync low when shutter open; B1: sync high when open.
// - C0: whole active configuration becomes factory default.
// - C1: copy active configuration into persistent store.
// - Reset loads stored configuration as active configuration.
// - A0: trigger input ignored, shutter state never changes.
module shutter_trigger_config_decoder (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trig_in,
    output logic shutter_open,
    output logic sync_out
);

    typedef enum logic [0:0] {WAIT_PREFIX, WAIT_CODE} parse_state_t;

    // Bus slave state
    logic aw_held, w_held;
    logic [3:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held, next_w_held;
    logic [3:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    // Command state
    parse_state_t state, next_state;
    shutter_cfg_pkg::config_t active_cfg, next_active_cfg;
    shutter_cfg_pkg::config_t saved_cfg, next_saved_cfg;
    logic done_valid, next_done_valid;
    logic trig_prev, next_trig_prev;
    logic next_shutter_open, next_sync_out;
    // Starts clear at power-up so the first edge seeds the store with defaults
    logic saved_init = 1'b0;
    logic next_saved_init;

    logic wr_fire, cmd_wr, status_rd;
    logic [7:0] cmd_byte;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid) && !s_axi_bvalid;
    assign cmd_byte = w_held ? w_data[7:0] : s_axi_wdata[7:0];

    // Write path: address and data may arrive in either order
    always_comb begin
        logic [3:0] addr;
        logic [3:0] strb;
        addr = aw_held ? aw_addr : s_axi_awaddr;
        strb = w_held ? w_strb : s_axi_wstrb;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        cmd_wr = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            // Only the command register is writable; byte lane 0 carries the byte
            if (addr == shutter_cfg_pkg::REG_CMD) begin
                next_bresp = shutter_cfg_pkg::RESP_OKAY;
                cmd_wr = strb[0];
            end else begin
                next_bresp = shutter_cfg_pkg::RESP_SLVERR;
            end
        end
    end

    // Read path; reading status consumes a pending completion byte
    always_comb begin
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        status_rd = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = shutter_cfg_pkg::RESP_OKAY;
            next_rdata = 32'h0000_0000;
            if (s_axi_araddr == shutter_cfg_pkg::REG_CMD) begin
                next_rdata = 32'h0000_0000;
            end else if (s_axi_araddr == shutter_cfg_pkg::REG_STATUS) begin
                status_rd = 1'b1;
                next_rdata[shutter_cfg_pkg::ST_DONE_VALID] = done_valid;
                next_rdata[shutter_cfg_pkg::ST_BUSY] = state == WAIT_CODE;
                next_rdata[shutter_cfg_pkg::ST_SHUTTER] = shutter_open;
                next_rdata[shutter_cfg_pkg::ST_SYNC] = sync_out;
                next_rdata[shutter_cfg_pkg::ST_TRIG] = trig_in;
                next_rdata[shutter_cfg_pkg::ST_DONE_LSB +: 8] =
                    done_valid ? shutter_cfg_pkg::CMD_DONE : 8'h00;
            end else if (s_axi_araddr == shutter_cfg_pkg::REG_CONFIG) begin
                next_rdata[4:0] = active_cfg;
            end else if (s_axi_araddr == shutter_cfg_pkg::REG_SAVED) begin
                next_rdata[4:0] = saved_cfg;
            end else begin
                next_rresp = shutter_cfg_pkg::RESP_SLVERR;
            end
        end
    end

    // Command parser, configuration and shutter logic
    always_comb begin
        logic rise, fall;
        rise = trig_in && !trig_prev;
        fall = !trig_in && trig_prev;
        next_state = state;
        next_active_cfg = active_cfg;
        next_saved_cfg = saved_cfg;
        next_saved_init = 1'b1;
        next_trig_prev = trig_in;
        next_shutter_open = shutter_open;
        // A new completion beats a read that clears the old one
        next_done_valid = done_valid && !status_rd;
        if (!saved_init) begin
            next_saved_cfg = shutter_cfg_pkg::FACTORY_CFG;
        end
        if (cmd_wr) begin
            case (state)
                WAIT_PREFIX: begin
                    // Stray bytes other than the prefix are dropped
                    if (cmd_byte == shutter_cfg_pkg::CMD_PREFIX) begin
                        next_state = WAIT_CODE;
                    end
                end
                WAIT_CODE: begin
                    next_state = WAIT_PREFIX;
                    next_done_valid = 1'b1;
                    case (cmd_byte)
                        shutter_cfg_pkg::CMD_TRIG_OFF: next_active_cfg.trig = shutter_cfg_pkg::TRIG_OFF;
                        shutter_cfg_pkg::CMD_TRIG_HIGH: next_active_cfg.trig = shutter_cfg_pkg::TRIG_HIGH;
                        shutter_cfg_pkg::CMD_TRIG_LOW: next_active_cfg.trig = shutter_cfg_pkg::TRIG_LOW;
                        shutter_cfg_pkg::CMD_TRIG_RISE: next_active_cfg.trig = shutter_cfg_pkg::TRIG_RISE;
                        shutter_cfg_pkg::CMD_TRIG_FALL: next_active_cfg.trig = shutter_cfg_pkg::TRIG_FALL;
                        shutter_cfg_pkg::CMD_SYNC_OFF: next_active_cfg.sync = shutter_cfg_pkg::SYNC_OFF;
                        shutter_cfg_pkg::CMD_SYNC_HIGH: next_active_cfg.sync = shutter_cfg_pkg::SYNC_HIGH;
                        shutter_cfg_pkg::CMD_SYNC_LOW: next_active_cfg.sync = shutter_cfg_pkg::SYNC_LOW;
                        shutter_cfg_pkg::CMD_RESTORE: next_active_cfg = shutter_cfg_pkg::FACTORY_CFG;
                        shutter_cfg_pkg::CMD_SAVE: next_saved_cfg = active_cfg;
                        default: next_done_valid = done_valid && !status_rd; // Unknown code: no answer
                    endcase
                end
                default: next_state = WAIT_PREFIX;
            endcase
        end
        // Shutter follows the trigger per the active mode
        case (active_cfg.trig)
            shutter_cfg_pkg::TRIG_HIGH: next_shutter_open = trig_in;
            shutter_cfg_pkg::TRIG_LOW: next_shutter_open = !trig_in;
            shutter_cfg_pkg::TRIG_RISE: next_shutter_open = shutter_open ^ rise;
            shutter_cfg_pkg::TRIG_FALL: next_shutter_open = shutter_open ^ fall;
            default: next_shutter_open = shutter_open;
        endcase
        // Sync output: idle level is the inverse of the open level, except SYNC_OFF holds it low
        case (active_cfg.sync)
            shutter_cfg_pkg::SYNC_HIGH: next_sync_out = next_shutter_open;
            shutter_cfg_pkg::SYNC_LOW: next_sync_out = !next_shutter_open;
            default: next_sync_out = 1'b0;
        endcase
    end

    // Saved configuration is kept across aresetn, like nonvolatile storage
    always_ff @(posedge aclk) begin
        saved_init <= next_saved_init;
        saved_cfg <= next_saved_cfg;
    end

    // Registers cleared or reloaded by reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 4'h0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'h0;
            s_axi_rdata <= 32'h0000_0000;
            state <= WAIT_PREFIX;
            done_valid <= 1'b0;
            trig_prev <= 1'b0;
            shutter_open <= 1'b0;
            sync_out <= 1'b0;
            // Stored copy is a register, not a port, so loading it here is legal
            active_cfg <= saved_init ? saved_cfg : shutter_cfg_pkg::FACTORY_CFG;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            state <= next_state;
            done_valid <= next_done_valid;
            trig_prev <= next_trig_prev;
            shutter_open <= next_shutter_open;
            sync_out <= next_sync_out;
            active_cfg <= next_active_cfg;
        end
    end

endmodule : shutter_trigger_config_decoder

// file: shared/shutter_cfg_pkg.sv
/*
 * Shared constants and types for the shutter trigger configuration decoder:
 * command bytes, mode encodings, register offsets and reset values.
 * Assumes a single 50 MHz clock domain and an AXI4-Lite register bus.
 */
package shutter_cfg_pkg;

    // Command framing bytes and command codes
    localparam logic [7:0] CMD_PREFIX = 8'hfa;
    localparam logic [7:0] CMD_DONE = 8'h0d;
    localparam logic [7:0] CMD_TRIG_OFF = 8'ha0;
    localparam logic [7:0] CMD_TRIG_HIGH = 8'ha1;
    localparam logic [7:0] CMD_TRIG_LOW = 8'ha2;
    localparam logic [7:0] CMD_TRIG_RISE = 8'ha3;
    localparam logic [7:0] CMD_TRIG_FALL = 8'ha4;
    localparam logic [7:0] CMD_SYNC_OFF = 8'hb0;
    localparam logic [7:0] CMD_SYNC_HIGH = 8'hb1;
    localparam logic [7:0] CMD_SYNC_LOW = 8'hb2;
    localparam logic [7:0] CMD_RESTORE = 8'hc0;
    localparam logic [7:0] CMD_SAVE = 8'hc1;

    typedef enum logic [2:0] {
        TRIG_OFF = 3'h0,
        TRIG_HIGH = 3'h1,
        TRIG_LOW = 3'h2,
        TRIG_RISE = 3'h3,
        TRIG_FALL = 3'h4
    } trig_mode_t;

    typedef enum logic [1:0] {
        SYNC_OFF = 2'h0,
        SYNC_HIGH = 2'h1,
        SYNC_LOW = 2'h2
    } sync_mode_t;

    typedef struct packed {
        trig_mode_t trig;
        sync_mode_t sync;
    } config_t;

    // Factory defaults
    localparam config_t FACTORY_CFG = '{trig: TRIG_OFF, sync: SYNC_HIGH};

    // Register byte offsets
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_CONFIG = 4'h8;
    localparam logic [3:0] REG_SAVED = 4'hc;

    // Status bit positions
    localparam int ST_DONE_VALID = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_SHUTTER = 2;
    localparam int ST_SYNC = 3;
    localparam int ST_TRIG = 4;
    localparam int ST_DONE_LSB = 8;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : shutter_cfg_pkg

// file: verification/shutter_cfg_asserts.sv
/*
 * Port-level assertions for the shutter command decoder.
 * Assumes the bench offers write address and data together.
 */
module shutter_cfg_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic trig_in,
    input wire logic shutter_open,
    input wire logic sync_out
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic wr;
    logic pend;
    logic ok;
    logic [7:0] tm;
    logic [7:0] sm;
    logic [1:0] age;
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr == 4'h0 && s_axi_wstrb[0];
    assign ok = age == 2'h3;
    // Shadow modes; after reset they are unknown, so checks wait for a command
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pend <= 1'b0;
            tm <= 8'h00;
            sm <= 8'h00;
            age <= 2'h0;
        end else if (wr) begin
            pend <= !pend && s_axi_wdata[7:0] == 8'hfa;
            age <= 2'h0;
            if (pend && s_axi_wdata[7:4] == 4'ha) tm <= s_axi_wdata[7:0];
            if (pend && s_axi_wdata[7:4] == 4'hb) sm <= s_axi_wdata[7:0];
            if (pend && s_axi_wdata[7:0] == 8'hc0) begin
                tm <= 8'ha0;
                sm <= 8'hb1;
            end
        end else if (!ok) begin
            age <= age + 2'h1;
        end
    end
    a_level_high:
    assert property (ok && tm == 8'ha1 |-> shutter_open == $past(trig_in)) else $error("hi lvl");
    a_level_low:
    assert property (ok && tm == 8'ha2 |-> shutter_open != $past(trig_in)) else $error("lo lvl");
    a_rise_toggle:
    assert property (ok && tm == 8'ha3 |-> shutter_open ==
        ($past(shutter_open) ^ ($past(trig_in) && !$past(trig_in, 2)))) else $error("rise");
    a_fall_toggle:
    assert property (ok && tm == 8'ha4 |-> shutter_open ==
        ($past(shutter_open) ^ (!$past(trig_in) && $past(trig_in, 2)))) else $error("fall");
    a_trig_ignored:
    assert property (ok && tm == 8'ha0 |-> $stable(shutter_open)) else $error("moved");
    a_sync_off:
    assert property (ok && sm == 8'hb0 |-> !sync_out) else $error("sync off");
    a_sync_high:
    assert property (ok && sm == 8'hb1 |-> sync_out == shutter_open) else $error("sync hi");
    a_sync_low:
    assert property (ok && sm == 8'hb2 |-> sync_out != shutter_open) else $error("sync lo");
    a_write_answer:
    assert property (s_wr_taken |=> s_axi_bvalid) else $error("no write response");
endmodule : shutter_cfg_asserts

bind shutter_trigger_config_decoder shutter_cfg_asserts chk_i (.*);

// file: verification/trig_source.sv
/*
 * Far-side trigger source: holds a level or sends a pulse train.
 * Changes only just after rising edges of aclk.
 */
module trig_source (
    input wire logic aclk,
    input wire logic lvl,
    input wire logic [3:0] pulses,
    input wire logic go,
    output logic busy,
    output logic trig_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] left;
    logic ph;
    initial begin
        trig_in = 1'b0;
        left = 5'h00;
        ph = 1'b0;
    end
    // Two cycles per level so any edge detector sees every pulse
    always @(posedge aclk) begin
        ph <= !ph;
        if (go) begin
            left <= {pulses, 1'b0};
            ph <= 1'b0;
        end else if (left != 5'h00 && ph) begin
            trig_in <= !trig_in;
            left <= left - 5'h01;
        end else if (left == 5'h00) begin
            trig_in <= lvl;
        end
    end
    assign busy = go || left != 5'h00;
endmodule : trig_source

// file: verification/shutter_trigger_config_decoder_tb.sv
/*
 * Self-checking bench: register tasks on AXI4-Lite, trigger source model.
 * Assumes saved configuration is factory default at power-up.
 */
module shutter_trigger_config_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'b0, aresetn = 1'b0, lvl = 1'b0, go = 1'b0, busy, trig_in;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, shutter_open, sync_out;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf, pulses = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_data;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
    // Order makes every step change the sync level, so a missed mode shows
    logic [7:0] sc [3] = '{8'hb2, 8'hb1, 8'hb0};
    logic se [3] = '{1'b0, 1'b1, 1'b0};
    int error_cnt = 0, checked = 0, cycles = 0;
    shutter_trigger_config_decoder uut (.*);
    trig_source far (.*);
    always #10 aclk = ~aclk;
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : conclude
    // Each channel is released at the edge where it is taken
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [1:0] exp_resp;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        // Only the command register accepts writes
        exp_resp = (a == shutter_cfg_pkg::REG_CMD) ? shutter_cfg_pkg::RESP_OKAY
            : shutter_cfg_pkg::RESP_SLVERR;
        chk("write response", s_axi_bresp, exp_resp);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
    endtask : rd
    task automatic cmd(input logic [7:0] code);
        wr(4'h0, 8'hfa);
        wr(4'h0, code);
        rd(4'h4);
        chk("completion byte", rd_data[15:8], 8'h0d);
    endtask : cmd
    // Level v held, or n pulses; then let the shutter settle
    task automatic trig(input logic v, input logic [3:0] n);
        @(posedge aclk);
        lvl <= v;
        pulses <= n;
        go <= n != 4'h0;
        @(posedge aclk);
        go <= 1'b0;
        while (busy) @(posedge aclk);
        repeat (3) @(posedge aclk);
    endtask : trig
    // Hang guard well above the few hundred cycles the tests need
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h8);
        chk("config", rd_data[4:0], 5'h01);
        rd(4'h2);
        chk("unmapped response", rd_resp, shutter_cfg_pkg::RESP_SLVERR);
        // Stray byte, bare prefix, unknown code and a write to the read-only config register
        wr(4'h0, 8'h42);
        rd(4'h4);
        chk("busy", rd_data[1], 1'b0);
        wr(4'h0, 8'hfa);
        rd(4'h4);
        chk("busy", rd_data[1], 1'b1);
        wr(4'h0, 8'h55);
        rd(4'h4);
        chk("done", rd_data[1:0], 2'h0);
        wr(4'h8, 8'ha1);
        rd(4'h8);
        chk("config", rd_data[4:0], 5'h01);
        $display("test bus errors finished");
        cmd(8'ha0);
        trig(1'b0, 4'h3);
        chk("shutter", shutter_open, 1'b0);
        $display("test ignored trigger finished");
        cmd(8'ha1);
        trig(1'b1, 4'h0);
        chk("shutter", shutter_open, 1'b1);
        trig(1'b0, 4'h0);
        chk("shutter", shutter_open, 1'b0);
        cmd(8'ha2);
        chk("shutter", shutter_open, 1'b1);
        trig(1'b1, 4'h0);
        chk("shutter", shutter_open, 1'b0);
        trig(1'b0, 4'h0);
        $display("test level modes finished");
        cmd(8'ha3);
        trig(1'b0, 4'h3);
        chk("shutter", shutter_open, 1'b0);
        cmd(8'ha4);
        trig(1'b0, 4'h1);
        chk("shutter", shutter_open, 1'b1);
        $display("test edge modes finished");
        for (int i = 0; i < 3; i++) begin
            cmd(sc[i]);
            chk("sync", sync_out, se[i]);
        end
        $display("test sync modes finished");
        cmd(8'hc1);
        cmd(8'hc0);
        rd(4'h8);
        chk("config", rd_data[4:0], 5'h01);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rd(4'h8);
        chk("config", rd_data[4:0], 5'h10);
        rd(4'hc);
        chk("saved", rd_data[4:0], 5'h10);
        trig(1'b0, 4'h1);
        chk("shutter", shutter_open, 1'b1);
        rd(4'h4);
        chk("status", rd_data[4:2], 3'h1);
        $display("test save and restore finished");
        conclude();
    end
endmodule : shutter_trigger_config_decoder_tb
